// File: core/hlt_timer.sv
// 8-bit hardware limit timer with postscaled period pulse and wishbone registers
// assumes source inputs are synchronous signals; tick_en paces the timer clock
// Behaviour
// - external reset signal chosen from sources by reset_source_select register
// - five-bit mode: upper two bits family, lower three bits variant
// - external signal ignored while debug freeze is high
// - software gate: count while on, hold otherwise, wrap after period match
// - hardware gate: count when on and signal active; 001 high, 010 low
// - edge reset free-run: any, rising, falling edge resets count
// - level reset free-run: held reset and stopped at reset level
// - after early external reset, restart period after two-clock delay
// - one-shot: period match next clock clears on, stops at zero
// - edge-start variants wait for qualifying edge after on set
// - after on cleared, a fresh edge is needed to resume
// - one-shot 100/101: first edge starts, later same edges reset
// - one-shot 110/111: edge starts, opposite level resets
// - monostable: match stops at zero keeping on; later edge restarts
// - level one-shot 10110/10111: run at active level, reset otherwise
// - period flag when postscaler reaches selected ratio 1:1 to 1:16
// - period interrupt reaches cpu only when enable bit set
// - on bit and external signal pass two-flop synchronisers
// - period match bumps postscaler; ratio match gives one-clock pulse, clears it
// - reset clears count, period ffh; count/control writes clear postscaler
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module hlt_timer
    import hlt_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // timer environment
    input wire logic tick_en,
    input wire logic debug_freeze,
    input wire logic [SRC_W-1:0] reset_sources,
    // outputs
    output logic postscaled_period_pulse,
    output logic period_irq,
    output logic [7:0] count_value
);
    function automatic logic mode_is(hlt_mode_t m, logic [1:0] f, logic [2:0] v);
        return (m.family == f) && (m.variant == v);
    endfunction

    logic on_r, on_nxt;
    hlt_mode_t mode_r;
    logic [SEL_W-1:0] rst_sel_r;
    logic [POST_W-1:0] post_sel_r, post_cnt_r;
    logic [7:0] count_r, period_r;
    logic flag_r, irq_en_r, ack_r;
    logic [31:0] dat_r;
    logic ers_s1_r, ers_s2_r, ers_d_r, on_s1_r, on_s2_r;
    logic armed_r;
    logic [1:0] dly_r;
    logic pulse_r, irq_r;
    hlt_state_t st_r;

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire [ADDR_MSB:ADDR_LSB] widx = wb_adr_i[ADDR_MSB:ADDR_LSB];
    wire wr_ctl = bus_wr && (wb_adr_i == ADDR_CONTROL);
    wire wr_lim = bus_wr && (wb_adr_i == ADDR_LIMIT_CTL);
    wire wr_sel = bus_wr && (wb_adr_i == ADDR_RST_SEL);
    wire wr_cnt = bus_wr && (wb_adr_i == ADDR_COUNT);
    wire wr_per = bus_wr && (wb_adr_i == ADDR_PERIOD);
    wire wr_sts = bus_wr && (wb_adr_i == ADDR_STATUS);
    wire wr_ien = bus_wr && (wb_adr_i == ADDR_IRQ_EN);

    // external signal selection and conditioning
    wire ers_raw = reset_sources[rst_sel_r];
    wire ers = ers_s2_r;
    wire frozen = debug_freeze;
    wire rise = tick_en & ~frozen & ers & ~ers_d_r;
    wire fall = tick_en & ~frozen & ~ers & ers_d_r;
    wire on_eff = on_s2_r & on_r;

    // mode decode
    wire gate_sw = mode_is(mode_r, FAM_FREE, V0);
    wire gate_hi = mode_is(mode_r, FAM_FREE, V1);
    wire gate_lo = mode_is(mode_r, FAM_FREE, V2);
    wire fr_any = mode_is(mode_r, FAM_FREE, V3);
    wire fr_rise = mode_is(mode_r, FAM_FREE, V4);
    wire fr_fall = mode_is(mode_r, FAM_FREE, V5);
    wire fr_lvl_lo = mode_is(mode_r, FAM_FREE, V6);
    wire fr_lvl_hi = mode_is(mode_r, FAM_FREE, V7);
    wire os_sw = mode_is(mode_r, FAM_ONESHOT, V0);
    wire os_family = mode_r.family == FAM_ONESHOT;
    wire mono = (mode_r.family == FAM_MONO) && (mode_r.variant >= V1) && (mode_r.variant <= V3);
    wire lv_hi = mode_is(mode_r, FAM_MONO, V6);
    wire lv_lo = mode_is(mode_r, FAM_MONO, V7);
    wire reserved = ~(mode_r.family == FAM_FREE) & ~os_family & ~mono & ~lv_hi & ~lv_lo;
    wire [2:0] v = mode_r.variant;
    wire edge_start_md = (os_family | mono) & (v != V0);
    // start edge per variant: 1/4/6 rising, 2/5/7 falling, 3 any
    wire start_edge = ((v == V1 || v == V4 || v == V6) & rise) |
                      ((v == V2 || v == V5 || v == V7) & fall) |
                      ((v == V3) & (rise | fall));
    wire gated = ~frozen & ((gate_hi & ~ers) | (gate_lo & ers));
    wire edge_rst = on_eff & ((fr_any & (rise | fall)) | (fr_rise & rise) | (fr_fall & fall) |
                    (os_family & (v == V4) & rise) | (os_family & (v == V5) & fall));
    wire lvl_rst = ~frozen & ((fr_lvl_lo & ~ers) | (fr_lvl_hi & ers) | (os_family & (v == V6) & ~ers) |
                   (os_family & (v == V7) & ers) | (lv_hi & ~ers) | (lv_lo & ers));
    wire lvl_run_ok = ~frozen & ((lv_hi & ers) | (lv_lo & ~ers));
    wire match = count_r == period_r;
    wire oneshot_stop = os_family | lv_hi | lv_lo;
    wire running = st_r == HLT_RUN;
    wire may_count = tick_en & on_eff & ~reserved & ~gated & ~lvl_rst & (dly_r == 2'h0) &
                     (running | gate_sw | gate_hi | gate_lo | (mode_r.family == FAM_FREE) |
                      os_sw | lvl_run_ok);
    wire period_evt = may_count & match;
    wire post_clr = wr_ctl | wr_cnt | edge_rst | (lvl_rst & on_eff);
    wire post_hit = period_evt & (post_cnt_r == post_sel_r);

    // run state: edge-start modes idle until a qualifying edge
    hlt_state_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        if (~on_eff | reserved)
            st_nxt = HLT_IDLE;
        else if (~edge_start_md)
            st_nxt = HLT_RUN;
        else if ((st_r != HLT_RUN) & armed_r & start_edge)
            st_nxt = HLT_RUN;
        else if (period_evt & mono)
            st_nxt = HLT_HOLD;
    end

    // on bit: software sets, one-shot completion clears
    always_comb
    begin
        on_nxt = on_r;
        if (wr_ctl)
            on_nxt = wb_dat_i[ON_BIT];
        if (period_evt & oneshot_stop)
            on_nxt = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            on_r <= 1'b0;
            mode_r <= MODE_RST;
            rst_sel_r <= RST_SEL_RST;
            post_sel_r <= '0;
            post_cnt_r <= '0;
            count_r <= COUNT_RST;
            period_r <= PERIOD_RST;
            flag_r <= 1'b0;
            irq_en_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= '0;
            ers_s1_r <= 1'b0;
            ers_s2_r <= 1'b0;
            ers_d_r <= 1'b0;
            on_s1_r <= 1'b0;
            on_s2_r <= 1'b0;
            armed_r <= 1'b0;
            dly_r <= 2'h0;
            pulse_r <= 1'b0;
            irq_r <= 1'b0;
            st_r <= HLT_IDLE;
        end
        else if (clk_en)
        begin
            ack_r <= bus_req;
            on_r <= on_nxt;
            on_s1_r <= on_r;
            on_s2_r <= on_s1_r;
            ers_s1_r <= ers_raw;
            ers_s2_r <= ers_s1_r;
            if (tick_en)
                ers_d_r <= ers_s2_r;
            st_r <= st_nxt;
            // arm edge detection only once the on bit is seen set
            armed_r <= on_eff;
            if (wr_lim)
                mode_r <= wb_dat_i[4:0];
            if (wr_sel)
                rst_sel_r <= wb_dat_i[SEL_W-1:0];
            if (wr_per)
                period_r <= wb_dat_i[7:0];
            if (wr_ctl)
                post_sel_r <= wb_dat_i[POST_LSB +: POST_W];
            if (wr_ien)
                irq_en_r <= wb_dat_i[0];
            if (edge_rst)
                dly_r <= RESTART_DLY;
            else if (tick_en && dly_r != 2'h0)
                dly_r <= dly_r - 2'h1;
            if (wr_cnt)
                count_r <= wb_dat_i[7:0];
            else if (edge_rst | (tick_en & lvl_rst & on_eff))
                count_r <= COUNT_RST;
            else if (period_evt)
                count_r <= COUNT_RST;
            else if (may_count & (st_nxt == HLT_RUN | ~edge_start_md))
                count_r <= count_r + 8'h01;
            if (post_clr)
                post_cnt_r <= '0;
            else if (post_hit)
                post_cnt_r <= '0;
            else if (period_evt)
                post_cnt_r <= post_cnt_r + 4'h1;
            pulse_r <= post_hit;
            // set wins over a software clear in the same cycle
            if (post_hit)
                flag_r <= 1'b1;
            else if (wr_sts & wb_dat_i[0])
                flag_r <= 1'b0;
            irq_r <= flag_r & irq_en_r;
            unique case (widx)
                ADDR_CONTROL[ADDR_MSB:ADDR_LSB]: dat_r <= {24'h0, on_r, 3'h0, post_sel_r};
                ADDR_LIMIT_CTL[ADDR_MSB:ADDR_LSB]: dat_r <= {27'h0, mode_r};
                ADDR_RST_SEL[ADDR_MSB:ADDR_LSB]: dat_r <= {28'h0, rst_sel_r};
                ADDR_COUNT[ADDR_MSB:ADDR_LSB]: dat_r <= {24'h0, count_r};
                ADDR_PERIOD[ADDR_MSB:ADDR_LSB]: dat_r <= {24'h0, period_r};
                ADDR_STATUS[ADDR_MSB:ADDR_LSB]: dat_r <= {29'h0, st_r == HLT_RUN, ers, flag_r};
                ADDR_IRQ_EN[ADDR_MSB:ADDR_LSB]: dat_r <= {31'h0, irq_en_r};
                default: dat_r <= 32'h0;
            endcase
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign postscaled_period_pulse = pulse_r;
    assign period_irq = irq_r;
    assign count_value = count_r;

    property p_period_wrap;
        @(posedge clock) disable iff (rst)
        (clk_en & period_evt & ~wr_cnt) |=> (count_r == COUNT_RST);
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("count did not wrap after match");

    property p_oneshot_clear;
        @(posedge clock) disable iff (rst)
        (clk_en & period_evt & oneshot_stop & ~wr_ctl) |=> ~on_r;
    endproperty
    a_oneshot_clear: assert property (p_oneshot_clear) else $error("one-shot left on set");

    property p_mono_keep_on;
        @(posedge clock) disable iff (rst)
        (clk_en & period_evt & mono & ~wr_ctl) |=> on_r;
    endproperty
    a_mono_keep_on: assert property (p_mono_keep_on) else $error("monostable cleared on");

    property p_pulse_one;
        @(posedge clock) disable iff (rst)
        (clk_en & pulse_r) |=> (~clk_en | ~pulse_r | $past(post_hit));
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("pulse wider than one clock");

    property p_irq_gate;
        @(posedge clock) disable iff (rst)
        period_irq |-> $past(irq_en_r);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

    property p_reserved_idle;
        @(posedge clock) disable iff (rst)
        (clk_en & reserved & ~wr_cnt) |=> $stable(count_r);
    endproperty
    a_reserved_idle: assert property (p_reserved_idle) else $error("reserved mode counted");

    sequence s_edge_rst;
        clk_en & edge_rst & ~wr_cnt;
    endsequence
    property p_restart_dly;
        @(posedge clock) disable iff (rst)
        s_edge_rst |=> (dly_r == RESTART_DLY) && (count_r == COUNT_RST);
    endproperty
    a_restart_dly: assert property (p_restart_dly) else $error("early reset delay wrong");

    property p_flag_set;
        @(posedge clock) disable iff (rst)
        (clk_en & post_hit) |=> flag_r && postscaled_period_pulse;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("period flag not raised");

    property p_freeze;
        @(posedge clock) disable iff (rst)
        debug_freeze |-> ~edge_rst;
    endproperty
    a_freeze: assert property (p_freeze) else $error("edge taken in freeze");

    // freeze must not reload the restart delay either
    property p_freeze_dly;
        @(posedge clock) disable iff (rst)
        (clk_en & debug_freeze & (dly_r == 2'h0)) |=> (dly_r == 2'h0);
    endproperty
    a_freeze_dly: assert property (p_freeze_dly) else $error("restart delay loaded in freeze");

    property p_src_pick;
        @(posedge clock) disable iff (rst)
        clk_en |=> (ers_s1_r == $past(ers_raw));
    endproperty
    a_src_pick: assert property (p_src_pick) else $error("wrong reset source taken");

    property p_sync_two;
        @(posedge clock) disable iff (rst)
        clk_en |=> (on_s1_r == $past(on_r)) && (ers_s2_r == $past(ers_s1_r));
    endproperty
    a_sync_two: assert property (p_sync_two) else $error("synchroniser stage skipped");

    property p_gate_hold;
        @(posedge clock) disable iff (rst)
        (clk_en & ~frozen & ((gate_hi & ~ers) | (gate_lo & ers)) & ~wr_cnt) |=> $stable(count_r);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate shut");

    property p_level_reset;
        @(posedge clock) disable iff (rst)
        (clk_en & tick_en & on_eff & ~frozen & ((fr_lvl_hi & ers) | (fr_lvl_lo & ~ers)) & ~wr_cnt)
            |=> (count_r == COUNT_RST);
    endproperty
    a_level_reset: assert property (p_level_reset) else $error("level reset not held");

    property p_os_level_reset;
        @(posedge clock) disable iff (rst)
        (clk_en & tick_en & on_eff & ~frozen & os_family & (((v == V6) & ~ers) | ((v == V7) & ers)) & ~wr_cnt)
            |=> (count_r == COUNT_RST);
    endproperty
    a_os_level_reset: assert property (p_os_level_reset) else $error("one-shot level reset missed");

    sequence s_os_edge;
        clk_en & on_eff & os_family & (((v == V4) & rise) | ((v == V5) & fall)) & ~wr_cnt;
    endsequence
    property p_os_edge_reset;
        @(posedge clock) disable iff (rst)
        s_os_edge |=> (count_r == COUNT_RST) && (dly_r == RESTART_DLY);
    endproperty
    a_os_edge_reset: assert property (p_os_edge_reset) else $error("one-shot edge reset missed");

    property p_off_idle;
        @(posedge clock) disable iff (rst)
        (clk_en & edge_start_md & ~on_eff) |=> (st_r == HLT_IDLE);
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("edge mode kept running when off");

    property p_wait_edge;
        @(posedge clock) disable iff (rst)
        (clk_en & edge_start_md & on_eff & (st_r == HLT_IDLE) & ~(armed_r & start_edge)) |=> (st_r != HLT_RUN);
    endproperty
    a_wait_edge: assert property (p_wait_edge) else $error("started without an edge");

    property p_mono_hold;
        @(posedge clock) disable iff (rst)
        (clk_en & mono & on_eff & (st_r == HLT_HOLD) & ~wr_cnt) |=> $stable(count_r);
    endproperty
    a_mono_hold: assert property (p_mono_hold) else $error("monostable counted while held");

    property p_lvl_os_run;
        @(posedge clock) disable iff (rst)
        (clk_en & tick_en & lv_hi & ers & on_eff & ~frozen & (dly_r == 2'h0) & ~match & ~wr_cnt)
            |=> (count_r == $past(count_r) + 8'h01);
    endproperty
    a_lvl_os_run: assert property (p_lvl_os_run) else $error("level one-shot not counting");

    property p_post_count;
        @(posedge clock) disable iff (rst)
        (clk_en & period_evt & ~post_hit & ~post_clr) |=> (post_cnt_r == $past(post_cnt_r) + 4'h1);
    endproperty
    a_post_count: assert property (p_post_count) else $error("postscaler not bumped");

    property p_post_clear;
        @(posedge clock) disable iff (rst)
        (clk_en & (wr_ctl | wr_cnt)) |=> (post_cnt_r == '0);
    endproperty
    a_post_clear: assert property (p_post_clear) else $error("postscaler kept after write");

    // ack is a single-cycle strobe so a held request is not taken twice
    property p_ack_one;
        @(posedge clock) disable iff (rst)
        (clk_en & wb_ack_o) |=> ~wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held for two cycles");
endmodule

// File: core/hlt_pkg.sv
// package for the hardware limit timer: register map, field layout, mode codes
// assumes a 32-bit classic wishbone slave with word-aligned registers
package hlt_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_LIMIT_CTL = 8'h04;
    localparam logic [7:0] ADDR_RST_SEL = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_PERIOD = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 7;

    // control register fields
    localparam int ON_BIT = 7;
    localparam int POST_LSB = 0;
    localparam int POST_W = 4;

    // reset values
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [3:0] RST_SEL_RST = 4'h0;
    localparam int SRC_W = 16;
    localparam int SEL_W = 4;

    // mode families and variants
    localparam logic [1:0] FAM_FREE = 2'h0;
    localparam logic [1:0] FAM_ONESHOT = 2'h1;
    localparam logic [1:0] FAM_MONO = 2'h2;
    localparam logic [2:0] V0 = 3'h0;
    localparam logic [2:0] V1 = 3'h1;
    localparam logic [2:0] V2 = 3'h2;
    localparam logic [2:0] V3 = 3'h3;
    localparam logic [2:0] V4 = 3'h4;
    localparam logic [2:0] V5 = 3'h5;
    localparam logic [2:0] V6 = 3'h6;
    localparam logic [2:0] V7 = 3'h7;

    // restart delay after an early external reset, in timer clocks
    localparam logic [1:0] RESTART_DLY = 2'h2;

    typedef struct packed {
        logic [1:0] family;
        logic [2:0] variant;
    } hlt_mode_t;

    typedef enum logic [2:0] {
        HLT_IDLE = 3'b001,
        HLT_RUN = 3'b010,
        HLT_HOLD = 3'b100
    } hlt_state_t;
endpackage

// File: sim/hlt_src_model.sv
// far-side model: the peripheral or pin feeding the selected reset source
// assumes the bench requests a level on want; unselected sources toggle every clock
`timescale 1ns/1ps
module hlt_src_model
    import hlt_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // bench request
    input wire logic [SEL_W-1:0] sel,
    input wire logic want,
    // sources seen by the timer
    output logic [SRC_W-1:0] reset_sources
);
    logic [2:0] gap_r;
    logic lvl_r;
    logic [SRC_W-1:0] noise_r;
    logic pass_w;
    // a change waits until six clocks passed since the last one
    assign pass_w = (want != lvl_r) && (gap_r >= 3'h6);
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            gap_r <= 3'h0;
            lvl_r <= 1'b0;
            noise_r <= 16'h5a5a;
        end
        else
        begin
            noise_r <= ~noise_r;
            if (pass_w)
            begin
                lvl_r <= want;
                gap_r <= 3'h0;
            end
            else if (gap_r < 3'h6)
                gap_r <= gap_r + 3'h1;
        end
    end
    // unselected lines keep changing so a wrong pick cannot pass unseen
    always_comb
    begin
        reset_sources = noise_r;
        reset_sources[sel] = lvl_r;
    end
endmodule

// File: sim/hlt_timer_tb.sv
// self-checking bench for the hardware limit timer
// assumes timer clock equals bus clock; source model on line 3
`timescale 1ns/1ps
module hlt_timer_tb
    import hlt_pkg::*;
;
    logic clock, rst, cyc, stb, we, ack, frz, want, pulse, irq;
    logic [7:0] adr, cnt, c0;
    logic [31:0] wdat, rdo, v;
    logic [SRC_W-1:0] srcs;
    logic [SEL_W-1:0] rsel;
    int miscompares, checks_done, n;

    hlt_timer u_hlt_timer (.clock(clock), .rst(rst), .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
        .tick_en(1'b1), .debug_freeze(frz), .reset_sources(srcs), .postscaled_period_pulse(pulse),
        .period_irq(irq), .count_value(cnt));
    hlt_src_model u_hlt_src_model (.clock(clock), .rst(rst), .sel(rsel), .want(want), .reset_sources(srcs));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task report_and_stop;
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task bail;
        miscompares++;
        report_and_stop();
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; read data taken at the ack edge
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        if (k >= 50)
            bail();
        v = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task step(input int k);
        repeat (k) @(negedge clock);
    endtask

    task drv(input logic f, input logic w);
        @(posedge clock);
        frz <= f;
        want <= w;
    endtask

    task wcnt(input logic [7:0] x);
        int k;
        k = 0;
        do
        begin
            @(negedge clock);
            k++;
        end
        while (cnt !== x && k < 600);
        if (k >= 600)
            bail();
    endtask

    // spacing between two output pulses, in clocks
    task pgap;
        wcnt(8'h02);
        n = 0;
        while (pulse !== 1'b1 && n < 300)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 300)
            bail();
        step(1);
        chk("pulse_width", 0, pulse);
        n = 1;
        while (pulse !== 1'b1 && n < 300)
        begin
            @(negedge clock);
            n++;
        end
    endtask

    initial
    begin
        {rst, cyc, stb, we, frz, want, adr, wdat} = {1'b1, 5'h0, 8'h00, 32'h0};
        rsel = 4'h3;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        chk("count_port", 0, cnt);
        acc(0, ADDR_PERIOD, 0);
        chk("period_reset", 32'hff, v);
        acc(0, ADDR_LIMIT_CTL, 0);
        chk("mode_reset", 0, v);
        acc(0, 8'h1c, 0);
        chk("unmapped", 0, v);
        // software gate, period 5, postscale 1:3
        acc(1, ADDR_PERIOD, 32'h05);
        acc(1, ADDR_CONTROL, 32'h82);
        wcnt(8'h05);
        step(1);
        chk("wrap", 0, cnt);
        pgap();
        chk("post_gap", 18, n);
        chk("irq_masked", 0, irq);
        acc(0, ADDR_STATUS, 0);
        chk("flag", 1, v[0]);
        acc(1, ADDR_IRQ_EN, 32'h1);
        step(1);
        chk("irq_on", 1, irq);
        acc(1, ADDR_CONTROL, 32'h0);
        acc(1, ADDR_STATUS, 32'h1);
        step(1);
        chk("irq_clear", 0, irq);
        c0 = cnt;
        step(5);
        chk("sw_hold", c0, cnt);
        // hardware gate active-high on source 3
        acc(1, ADDR_RST_SEL, 32'h3);
        acc(1, ADDR_LIMIT_CTL, 32'h01);
        acc(1, ADDR_PERIOD, 32'hff);
        acc(1, ADDR_COUNT, 32'h0);
        acc(1, ADDR_CONTROL, 32'h80);
        step(8);
        chk("gate_low", 0, cnt);
        drv(0, 1);
        step(10);
        chk("gate_high", 1, cnt !== 8'h00);
        drv(0, 0);
        step(6);
        c0 = cnt;
        step(5);
        chk("gate_stop", c0, cnt);
        // rising edge reset, falling ignored, freeze ignores all
        acc(1, ADDR_LIMIT_CTL, 32'h04);
        step(20);
        c0 = cnt;
        drv(0, 1);
        step(8);
        chk("edge_reset", 1, cnt < c0);
        c0 = cnt;
        drv(0, 0);
        step(8);
        chk("fall_ignored", c0 + 8, cnt);
        c0 = cnt;
        drv(1, 1);
        step(8);
        chk("freeze", c0 + 8, cnt);
        drv(1, 0);
        step(8);
        drv(0, 0);
        // high level reset, then resume on release
        acc(1, ADDR_LIMIT_CTL, 32'h07);
        drv(0, 1);
        step(10);
        chk("level_reset", 0, cnt);
        drv(0, 0);
        step(10);
        chk("level_release", 1, cnt !== 8'h00);
        // software start one-shot
        acc(1, ADDR_CONTROL, 32'h0);
        acc(1, ADDR_LIMIT_CTL, 32'h08);
        acc(1, ADDR_PERIOD, 32'h03);
        acc(1, ADDR_COUNT, 32'h0);
        acc(1, ADDR_CONTROL, 32'h80);
        wcnt(8'h03);
        step(4);
        chk("oneshot_stop", 0, cnt);
        acc(0, ADDR_CONTROL, 0);
        chk("oneshot_on", 0, v[ON_BIT]);
        // rising edge monostable
        acc(1, ADDR_LIMIT_CTL, 32'h11);
        acc(1, ADDR_CONTROL, 32'h80);
        step(10);
        chk("mono_idle", 0, cnt);
        drv(0, 1);
        wcnt(8'h03);
        step(4);
        chk("mono_stop", 0, cnt);
        acc(0, ADDR_CONTROL, 0);
        chk("mono_on", 1, v[ON_BIT]);
        drv(0, 0);
        step(10);
        chk("mono_fall", 0, cnt);
        drv(0, 1);
        wcnt(8'h03);
        // reserved code stays inert
        acc(1, ADDR_CONTROL, 32'h0);
        acc(1, ADDR_LIMIT_CTL, 32'h18);
        acc(1, ADDR_CONTROL, 32'h80);
        drv(0, 0);
        step(8);
        drv(0, 1);
        step(10);
        chk("reserved", 0, cnt);
        // level one-shot runs while signal high
        acc(1, ADDR_LIMIT_CTL, 32'h16);
        wcnt(8'h03);
        step(4);
        chk("lvl_oneshot", 0, cnt);
        // rising start, later rising edges reset the count
        acc(1, ADDR_CONTROL, 32'h0);
        acc(1, ADDR_LIMIT_CTL, 32'h0c);
        acc(1, ADDR_PERIOD, 32'hff);
        acc(1, ADDR_COUNT, 32'h0);
        drv(0, 0);
        acc(1, ADDR_CONTROL, 32'h80);
        step(8);
        drv(0, 1);
        step(12);
        c0 = cnt;
        drv(0, 0);
        step(8);
        drv(0, 1);
        step(5);
        chk("os_edge_reset", 1, cnt < c0);
        report_and_stop();
    end
endmodule
